/* File: rtl/otsw_pkg.sv */
// Package of constants and types for the overtravel stop and warning block
package otsw_pkg;

    // ************************************************************
    // Register map (word aligned byte addresses)
    // ************************************************************
    localparam logic [7:0] OTSW_ADDR_STOP_SET  = 8'h00; // Stop method setting
    localparam logic [7:0] OTSW_ADDR_ESTOP_TRQ = 8'h04; // Emergency stop torque
    localparam logic [7:0] OTSW_ADDR_WARN_EN   = 8'h08; // Warning enable
    localparam logic [7:0] OTSW_ADDR_MAX_TRQ   = 8'h0C; // Motor maximum torque
    localparam logic [7:0] OTSW_ADDR_ZERO_SPD  = 8'h10; // Zero speed threshold
    localparam logic [7:0] OTSW_ADDR_STATUS    = 8'h14; // Live state, read only
    localparam logic [7:0] OTSW_ADDR_IRQ_STAT  = 8'h18; // Sticky events, read only
    localparam logic [7:0] OTSW_ADDR_IRQ_EN    = 8'h1C; // Interrupt enable
    localparam logic [7:0] OTSW_ADDR_IRQ_CLR   = 8'h20; // Write one to clear

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int OTSW_DIGIT0_LSB = 0;  // Stop method digit
    localparam int OTSW_DIGIT1_LSB = 4;  // Post stop digit
    localparam int OTSW_TRQ_W      = 10; // Torque field width, percent
    localparam int OTSW_SPD_W      = 16; // Speed field width
    localparam logic [7:0]  OTSW_STOP_SET_RST  = 8'h00;
    localparam logic [9:0]  OTSW_ESTOP_TRQ_RST = 10'h320; // 800 percent
    localparam logic [9:0]  OTSW_ESTOP_TRQ_MAX = 10'h320; // Upper bound 800
    localparam logic [9:0]  OTSW_MAX_TRQ_RST   = 10'h12C; // Plain default, 300 percent
    localparam logic [15:0] OTSW_ZERO_SPD_RST  = 16'h0010;
    localparam logic [3:0]  OTSW_DIG_DB        = 4'h0; // Short circuit braking
    localparam logic [3:0]  OTSW_DIG_COAST     = 4'h1;
    localparam logic [3:0]  OTSW_DIG_DECEL     = 4'h2; // Digit0 value 2
    localparam logic [3:0]  OTSW_DIG_CLAMP     = 4'h1; // Digit1 value 1
    localparam logic [3:0]  OTSW_DIG_POSTCOAST = 4'h2; // Digit1 value 2
    localparam int OTSW_EV_WARN = 0; // Event bit: warning raised
    localparam int OTSW_EV_STOP = 1; // Event bit: overtravel stop began
    localparam int OTSW_EV_W    = 2;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int OTSW_CLK_HZ       = 25000000;
    localparam int OTSW_HOLD_MS      = 1000; // Warning hold after limit clears
    localparam int OTSW_HOLD_CYCLES  = OTSW_CLK_HZ / 1000 * OTSW_HOLD_MS;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {OTSW_ACT_RUN, OTSW_ACT_DB, OTSW_ACT_COAST,
                              OTSW_ACT_DECEL} otsw_act_t;
    typedef enum {OTSW_ST_NORMAL, OTSW_ST_STOPPING, OTSW_ST_STOPPED} otsw_state_t;

endpackage

/* File: rtl/otsw_warn.sv */
// Overtravel warning qualifier with one second hold
`timescale 1ns/1ps
module otsw_warn
    import otsw_pkg::*;
#(
    parameter int HOLD_CYCLES = OTSW_HOLD_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic enable,       // Warning detection enabled
    input  wire logic power_on,     // Motor power state
    input  wire logic fwd_ot,       // Forward overtravel, synchronised
    input  wire logic rev_ot,       // Reverse overtravel, synchronised
    input  wire logic ref_fwd,      // Forward reference active
    input  wire logic ref_rev,      // Reverse reference active
    output logic      warn,         // Warning level toward host
    output logic      warn_rise     // One cycle pulse at raise
);

    // ************************************************************
    // Qualification
    // ************************************************************
    logic        power_q;     // Power one cycle ago
    logic        armed;       // Powered, and overtravel seen clear at or since the power on edge
    logic [31:0] hold_cnt;    // Remaining hold cycles
    wire  logic  no_ref   = !ref_fwd && !ref_rev;
    // Direction match, or either limit when no reference
    wire  logic  dir_hit  = (fwd_ot && (ref_fwd || no_ref)) || (rev_ot && (ref_rev || no_ref));
    wire  logic  any_ot   = fwd_ot || rev_ot;
    wire  logic  detect   = enable && power_on && armed && dir_hit;

    // Arming: a condition present at power on is ignored until it clears
    always_ff @(posedge core_clk) begin
        if (reset) begin
            power_q <= 1'b0;
            armed   <= 1'b0;
        end else begin
            power_q <= power_on;
            if (!power_on) begin
                armed <= 1'b0;
            end else if (!power_q) begin
                armed <= !any_ot;
            end else if (!any_ot) begin
                armed <= 1'b1;
            end
        end
    end

    // Hold counter restarts while detecting, decays after
    always_ff @(posedge core_clk) begin
        if (reset) begin
            hold_cnt  <= 32'h0;
            warn      <= 1'b0;
            warn_rise <= 1'b0;
        end else begin
            warn_rise <= detect && !warn;
            if (detect) begin
                warn     <= 1'b1;
                hold_cnt <= 32'(HOLD_CYCLES);
            end else if (warn && !enable) begin
                warn     <= 1'b0; // Disabling drops it at once
                hold_cnt <= 32'h0;
            end else if (hold_cnt > 32'h1) begin
                hold_cnt <= hold_cnt - 32'h1;
            end else begin
                warn     <= 1'b0;
                hold_cnt <= 32'h0;
            end
        end
    end

endmodule

/* File: rtl/otsw_top.sv */
// Overtravel stop selection, warning and brake output with Wishbone registers
//
// Overview of operation
// - Limit while running: digit0 braking or coast
// - Decel digit: estop torque, then clamp or coast
// - Zero clamp holds position loop at zero
// - Torque control: no decel, coast after stop
// - Estop torque 0 to 800, default 800
// - Applied estop torque clipped to motor maximum
// - Warning detection only when enable digit is 1
// - Warn on overtravel with power on, even brief
// - Warn only for limit matching reference direction
// - No reference: either limit raises warning
// - No warning raised while motor power is off; one already held runs out its hold
// - No warning for overtravel present at power on
// - Warning held one second after clear, auto cleared
// - Warning is notice only, stop unaffected
// - Deasserted limit input prohibits that direction
// - Opposite direction references still accepted
// - Brake output on releases, off applies
`timescale 1ns/1ps
module otsw_top
    import otsw_pkg::*;
#(
    parameter int HOLD_CYCLES = OTSW_HOLD_CYCLES // Shorten for simulation
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Machine pins, asynchronous
    input  wire logic        forward_limit_input,  // High allows forward run
    input  wire logic        reverse_limit_input,  // High allows reverse run
    // Drive core, same clock
    input  wire logic        servo_enable,         // Motor power on request
    input  wire logic        torque_mode,          // Torque control active
    input  wire logic        ref_forward,          // Forward reference active
    input  wire logic        ref_reverse,          // Reverse reference active
    input  wire logic [15:0] speed_abs,            // Measured speed magnitude
    // Outputs to the drive core and host
    output logic             motor_power,          // Motor current allowed
    output logic [1:0]       stop_action,          // otsw_act_t encoding
    output logic [9:0]       decel_torque,         // Applied estop torque, percent
    output logic             zero_clamp,           // Position loop at zero ref
    output logic             allow_forward,        // Forward motion permitted
    output logic             allow_reverse,        // Reverse motion permitted
    output logic             limit_warning_code,   // Overtravel warning level
    output logic             brake_release_output, // High releases the brake
    output logic             irq
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [1:0] fwd_sync; // Bit 0 is read only by bit 1
    logic [1:0] rev_sync;

    // Two stage capture of the limit switches
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fwd_sync <= 2'b11;
            rev_sync <= 2'b11;
        end else begin
            fwd_sync <= {fwd_sync[0], forward_limit_input};
            rev_sync <= {rev_sync[0], reverse_limit_input};
        end
    end

    // Deasserted switch means that direction is in overtravel
    wire logic fwd_ot = !fwd_sync[1];
    wire logic rev_ot = !rev_sync[1];

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0]           overtravel_stop_setting; // Digit1:digit0
    logic [9:0]           emergency_stop_torque;   // Percent of rated
    logic                 limit_warning_enable;    // Digit3 of warning setting
    logic [9:0]           max_torque;              // Motor maximum, percent
    logic [15:0]          zero_speed;              // Stopped threshold
    logic [OTSW_EV_W-1:0] irq_stat;                // Sticky events
    logic [OTSW_EV_W-1:0] irq_en;                  // Event enables

    // Bus decode
    wire logic        wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic        wb_wr    = wb_req && wb_we_i;
    wire logic        wr_lo    = wb_wr && wb_sel_i[0];
    wire logic        wr_hi    = wb_wr && wb_sel_i[1];
    wire logic [15:0] wdat16   = wb_dat_i[15:0];
    // Torque write clamped into 0..800
    wire logic [9:0]  trq_wr   = (wdat16 > 16'(OTSW_ESTOP_TRQ_MAX)) ?
                                 OTSW_ESTOP_TRQ_MAX : wdat16[9:0];
    wire logic [OTSW_EV_W-1:0] ev_set;
    wire logic [OTSW_EV_W-1:0] ev_clr = (wr_lo && wb_adr_i == OTSW_ADDR_IRQ_CLR) ?
                                        wb_dat_i[OTSW_EV_W-1:0] : '0;

    // Merges byte lanes into a 16 bit field
    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [15:0] nw,
                                           input logic lo, input logic hi);
        lane16 = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
    endfunction

    wire logic [15:0] trq_merge = lane16({6'h0, emergency_stop_torque}, 16'(trq_wr),
                                         wr_lo, wr_hi);
    wire logic [15:0] max_merge = lane16({6'h0, max_torque}, wdat16, wr_lo, wr_hi);

    // Read mux, unmapped reads as zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (wb_adr_i)
            OTSW_ADDR_STOP_SET:  rd_mux = {24'h0, overtravel_stop_setting};
            OTSW_ADDR_ESTOP_TRQ: rd_mux = {22'h0, emergency_stop_torque};
            OTSW_ADDR_WARN_EN:   rd_mux = {31'h0, limit_warning_enable};
            OTSW_ADDR_MAX_TRQ:   rd_mux = {22'h0, max_torque};
            OTSW_ADDR_ZERO_SPD:  rd_mux = {16'h0, zero_speed};
            OTSW_ADDR_STATUS:    rd_mux = {24'h0, motor_power, zero_clamp,
                                           stop_action, rev_ot, fwd_ot,
                                           limit_warning_code, brake_release_output};
            OTSW_ADDR_IRQ_STAT:  rd_mux = {30'h0, irq_stat};
            OTSW_ADDR_IRQ_EN:    rd_mux = {30'h0, irq_en};
            default:             rd_mux = 32'h0;
        endcase
    end

    // Ack one cycle after request, dropped the cycle after
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_mux : 32'h0;
        end
    end

    // Register writes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            overtravel_stop_setting <= OTSW_STOP_SET_RST;
            emergency_stop_torque   <= OTSW_ESTOP_TRQ_RST;
            limit_warning_enable    <= 1'b0;
            max_torque              <= OTSW_MAX_TRQ_RST;
            zero_speed              <= OTSW_ZERO_SPD_RST;
            irq_en                  <= '0;
        end else begin
            if (wr_lo && wb_adr_i == OTSW_ADDR_STOP_SET) begin
                overtravel_stop_setting <= wb_dat_i[7:0];
            end
            if (wb_wr && wb_adr_i == OTSW_ADDR_ESTOP_TRQ) begin
                emergency_stop_torque <= trq_merge[9:0];
            end
            if (wr_lo && wb_adr_i == OTSW_ADDR_WARN_EN) begin
                limit_warning_enable <= wb_dat_i[0];
            end
            if (wb_wr && wb_adr_i == OTSW_ADDR_MAX_TRQ) begin
                max_torque <= max_merge[9:0];
            end
            if (wb_wr && wb_adr_i == OTSW_ADDR_ZERO_SPD) begin
                zero_speed <= lane16(zero_speed, wdat16, wr_lo, wr_hi);
            end
            if (wr_lo && wb_adr_i == OTSW_ADDR_IRQ_EN) begin
                irq_en <= wb_dat_i[OTSW_EV_W-1:0];
            end
        end
    end

    // Sticky events, a new event wins over a same cycle clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_stat <= '0;
            irq      <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~ev_clr) | ev_set;
            irq      <= |(((irq_stat & ~ev_clr) | ev_set) & irq_en);
        end
    end

    // ************************************************************
    // Stop method selection
    // ************************************************************
    otsw_state_t state;
    otsw_state_t next_state;
    wire logic [3:0] dig0     = overtravel_stop_setting[OTSW_DIGIT0_LSB +: 4];
    wire logic [3:0] dig1     = overtravel_stop_setting[OTSW_DIGIT1_LSB +: 4];
    // Overtravel applies when moving or commanded into the closed side
    wire logic       ot_hit   = (fwd_ot && !ref_reverse) || (rev_ot && !ref_forward);
    wire logic       stopped  = speed_abs < zero_speed;
    wire logic       use_dec  = (dig1 == OTSW_DIG_CLAMP || dig1 == OTSW_DIG_POSTCOAST) &&
                                !torque_mode;
    wire logic       do_clamp = use_dec && (dig1 == OTSW_DIG_CLAMP);
    // Torque mode falls back to the whole dig0 digit: 0 braking, any other value coast
    wire otsw_act_t  sel_act  = use_dec ? OTSW_ACT_DECEL :
                                (dig0 == OTSW_DIG_DB) ? OTSW_ACT_DB : OTSW_ACT_COAST;
    // Clip applied torque to motor maximum
    wire logic [9:0] trq_clip = (emergency_stop_torque > max_torque) ?
                                max_torque : emergency_stop_torque;
    assign ev_set[OTSW_EV_STOP] = (state == OTSW_ST_NORMAL) && servo_enable && ot_hit &&
                                  !stopped;

    // Next state: stop processing ignores the warning entirely
    always_comb begin
        next_state = state;
        unique case (state)
            OTSW_ST_NORMAL:   if (servo_enable && ot_hit) begin
                                  next_state = stopped ? OTSW_ST_STOPPED : OTSW_ST_STOPPING;
                              end
            OTSW_ST_STOPPING: if (!ot_hit || !servo_enable) begin
                                  next_state = OTSW_ST_NORMAL;
                              end else if (stopped) begin
                                  next_state = OTSW_ST_STOPPED;
                              end
            OTSW_ST_STOPPED:  if (!ot_hit || !servo_enable) begin
                                  next_state = OTSW_ST_NORMAL;
                              end
        endcase
    end

    // Stop actions registered so outputs come from flops
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state         <= OTSW_ST_NORMAL;
            stop_action   <= OTSW_ACT_RUN;
            decel_torque  <= 10'h0;
            zero_clamp    <= 1'b0;
            motor_power   <= 1'b0;
            allow_forward <= 1'b0;
            allow_reverse <= 1'b0;
        end else begin
            state         <= next_state;
            motor_power   <= servo_enable;
            allow_forward <= !fwd_ot;
            allow_reverse <= !rev_ot;
            unique case (next_state)
                OTSW_ST_STOPPING: begin
                    stop_action  <= sel_act;
                    decel_torque <= use_dec ? trq_clip : 10'h0;
                    zero_clamp   <= 1'b0;
                end
                OTSW_ST_STOPPED: begin
                    // Post stop: clamp if selected, else coast
                    stop_action  <= do_clamp ? OTSW_ACT_RUN : OTSW_ACT_COAST;
                    decel_torque <= 10'h0;
                    zero_clamp   <= do_clamp;
                end
                default: begin
                    stop_action  <= OTSW_ACT_RUN;
                    decel_torque <= 10'h0;
                    zero_clamp   <= 1'b0;
                end
            endcase
        end
    end

    // Brake released while powered, overtravel keeps it released
    always_ff @(posedge core_clk) begin
        if (reset) begin
            brake_release_output <= 1'b0;
        end else begin
            brake_release_output <= servo_enable;
        end
    end

    // ************************************************************
    // Overtravel warning
    // ************************************************************
    otsw_warn #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_warn (
        .core_clk  (core_clk),
        .reset     (reset),
        .enable    (limit_warning_enable),
        .power_on  (servo_enable),
        .fwd_ot    (fwd_ot),
        .rev_ot    (rev_ot),
        .ref_fwd   (ref_forward),
        .ref_rev   (ref_reverse),
        .warn      (limit_warning_code),
        .warn_rise (ev_set[OTSW_EV_WARN])
    );

endmodule

/* File: dv/otsw_host_model.sv */
// Host controller model: servo enable, brake wait and direction references
`timescale 1ns/1ps
module otsw_host_model #(
    parameter int BRAKE_WAIT = 20 // Brake release plus 50 ms, shortened
) (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       power_req, // Motor power wanted
    input  wire logic [1:0] dir_req,   // Bit0 forward, bit1 reverse
    output logic            servo_enable,
    output logic            ref_forward,
    output logic            ref_reverse,
    output logic            ready      // Wait over, references may go out
);
    int wait_cnt; // Cycles since servo enable rose
    // References held back until the brake has surely released
    assign ready       = servo_enable && (wait_cnt >= BRAKE_WAIT);
    assign ref_forward = ready && dir_req[0];
    assign ref_reverse = ready && dir_req[1];
    // Enable follows the request, counter saturates at the wait
    always_ff @(posedge core_clk) begin
        servo_enable <= !reset && power_req;
        if (reset || !servo_enable) begin
            wait_cnt <= 0;
        end else if (wait_cnt < BRAKE_WAIT) begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule

/* File: dv/otsw_top_asserts.sv */
// Port checker for the overtravel stop and warning block
`timescale 1ns/1ps
module otsw_top_asserts
    import otsw_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        forward_limit_input,
    input wire logic        servo_enable,
    input wire logic        torque_mode,
    input wire logic [1:0]  stop_action,
    input wire logic [9:0]  decel_torque,
    input wire logic        zero_clamp,
    input wire logic        allow_forward,
    input wire logic        limit_warning_code,
    input wire logic        brake_release_output
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat not 0");
    brake_follow_a: assert property (!$past(reset) |->
        brake_release_output == $past(servo_enable)) else $error("brake wrong");
    fwd_block_a: assert property ($fell(allow_forward) && !$past(reset) |->
        !$past(forward_limit_input, 3)) else $error("forward blocked early");
    torque_nodecel_a: assert property (torque_mode |->
        stop_action != OTSW_ACT_DECEL) else $error("decel in torque mode");
    clamp_run_a: assert property (zero_clamp |-> stop_action == OTSW_ACT_RUN)
        else $error("clamp with stop action");
    decel_trq_a: assert property (stop_action != OTSW_ACT_DECEL |->
        decel_torque == 10'h000) else $error("torque outside decel");
    trq_bound_a: assert property (decel_torque <= OTSW_ESTOP_TRQ_MAX)
        else $error("torque above bound");
    warn_power_a: assert property ($rose(limit_warning_code) |->
        $past(servo_enable) || $past(servo_enable, 2)) else $error("warn unpowered");
    cover property (stop_action == OTSW_ACT_DECEL);
    cover property ($rose(zero_clamp));
    cover property ($rose(limit_warning_code));
endmodule
bind otsw_top otsw_top_asserts chk (.core_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
    .wb_ack_o, .forward_limit_input, .servo_enable, .torque_mode, .stop_action,
    .decel_torque, .zero_clamp, .allow_forward, .limit_warning_code, .brake_release_output);

/* File: dv/otsw_top_tb.sv */
// Self-checking bench for the overtravel stop and warning block
`timescale 1ns/1ps
module otsw_top_tb
    import otsw_pkg::*;
;
    typedef struct {logic [7:0] set; logic tq; logic [1:0] act, post; logic clamp;
                    logic [9:0] trq;} otsw_row_t;
    // Stop method rows, motor maximum torque set to 100 so decel clips
    otsw_row_t rows [6] = '{'{8'h00, 1'h0, 2'h1, 2'h2, 1'h0, 10'h000},
        '{8'h01, 1'h0, 2'h2, 2'h2, 1'h0, 10'h000}, '{8'h12, 1'h0, 2'h3, 2'h0, 1'h1, 10'h064},
        '{8'h22, 1'h0, 2'h3, 2'h2, 1'h0, 10'h064}, '{8'h12, 1'h1, 2'h2, 2'h2, 1'h0, 10'h000},
        '{8'h10, 1'h1, 2'h1, 2'h2, 1'h0, 10'h000}};
    logic        core_clk, reset, cyc, stb, we, ack, fwd_lim, rev_lim, tq_mode, power_req;
    logic        servo_en, ref_f, ref_r, ready, mpow, clamp, allow_f, allow_r, warn, brake, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_i, dat_o, rd;
    logic [15:0] speed;
    logic [1:0]  dir_req, act;
    logic [9:0]  trq;
    int          err_count, n_tests;
    otsw_top #(.HOLD_CYCLES(50)) uut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .forward_limit_input(fwd_lim),
        .reverse_limit_input(rev_lim), .servo_enable(servo_en), .torque_mode(tq_mode),
        .ref_forward(ref_f), .ref_reverse(ref_r), .speed_abs(speed), .motor_power(mpow),
        .stop_action(act), .decel_torque(trq), .zero_clamp(clamp), .allow_forward(allow_f),
        .allow_reverse(allow_r), .limit_warning_code(warn), .brake_release_output(brake),
        .irq(irq));
    otsw_host_model #(.BRAKE_WAIT(20)) host (.core_clk(core_clk), .reset(reset),
        .power_req(power_req), .dir_req(dir_req), .servo_enable(servo_en),
        .ref_forward(ref_f), .ref_reverse(ref_r), .ready(ready));
    // Free running clock, 40 ns period
    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // One classic Wishbone cycle; ack sampled at the edge, released after it
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        {cyc, stb, we, adr, sel, dat_i} <= {2'h3, w, a, 4'hF, d};
        do begin
            @(posedge core_clk);
        end while (ack !== 1'h1);
        rd = dat_o;
        {cyc, stb, we} <= 3'h0;
        @(posedge core_clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'h0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        #(20000 * 40);
        err_count++;
        close_out();
    end
    // Main sequence
    initial begin
        {reset, fwd_lim, rev_lim, cyc, stb, we, tq_mode, power_req} = 8'hE0;
        {adr, sel, dat_i, speed, dir_req} = '0;
        repeat (5) @(posedge core_clk);
        reset <= 1'h0;
        rd_chk("estop rst", OTSW_ADDR_ESTOP_TRQ, 32'h320);
        rd_chk("maxtrq rst", OTSW_ADDR_MAX_TRQ, 32'h12C);
        rd_chk("warn en rst", OTSW_ADDR_WARN_EN, 32'h0);
        rd_chk("unmapped", 8'h30, 32'h0);
        xfer(1'h1, OTSW_ADDR_ESTOP_TRQ, 32'h384);
        rd_chk("estop clamp", OTSW_ADDR_ESTOP_TRQ, 32'h320);
        xfer(1'h1, OTSW_ADDR_MAX_TRQ, 32'h64);
        speed <= 16'h0100;
        power_req <= 1'h1;
        wait_n(30);
        chk("brake on", {30'h0, brake, mpow}, 32'h3);
        rd_chk("status", OTSW_ADDR_STATUS, 32'h81);
        foreach (rows[i]) begin
            xfer(1'h1, OTSW_ADDR_STOP_SET, {24'h0, rows[i].set});
            tq_mode <= rows[i].tq;
            fwd_lim <= 1'h0;
            wait_n(6);
            chk("stop act", 32'(act), 32'(rows[i].act));
            chk("decel trq", 32'(trq), 32'(rows[i].trq));
            chk("allow f r", {30'h0, allow_f, allow_r}, 32'h1);
            speed <= 16'h0000;
            wait_n(4);
            chk("post", {29'h0, clamp, act}, {29'h0, rows[i].clamp, rows[i].post});
            fwd_lim <= 1'h1;
            speed <= 16'h0100;
            wait_n(6);
            chk("released", 32'(act), 32'h0);
        end
        tq_mode <= 1'h0;
        xfer(1'h1, OTSW_ADDR_WARN_EN, 32'h1);
        xfer(1'h1, OTSW_ADDR_IRQ_EN, 32'h1);
        // Reverse limit against a forward reference stays silent
        {dir_req, rev_lim} <= 3'h2;
        wait_n(6);
        chk("warn wrong dir", 32'(warn), 32'h0);
        {dir_req, rev_lim} <= 3'h3;
        wait_n(6);
        dir_req <= 2'h0;
        // One cycle glitch with no reference still warns, then holds
        rev_lim <= 1'h0;
        wait_n(1);
        rev_lim <= 1'h1;
        wait_n(5);
        chk("warn brief", {30'h0, warn, irq}, 32'h3);
        wait_n(40);
        chk("warn held", 32'(warn), 32'h1);
        wait_n(20);
        chk("warn cleared", 32'(warn), 32'h0);
        xfer(1'h1, OTSW_ADDR_IRQ_CLR, 32'h3);
        chk("irq cleared", 32'(irq), 32'h0);
        xfer(1'h1, OTSW_ADDR_IRQ_EN, 32'h0);
        {dir_req, fwd_lim} <= 3'h2;
        wait_n(6);
        chk("warn match masked", {30'h0, warn, irq}, 32'h2);
        xfer(1'h0, OTSW_ADDR_IRQ_STAT, 32'h0);
        chk("irq sticky", 32'(rd[0]), 32'h1);
        {dir_req, fwd_lim, power_req} <= 4'h2;
        wait_n(70);
        fwd_lim <= 1'h0;
        wait_n(6);
        chk("warn power off", 32'(warn), 32'h0);
        power_req <= 1'h1;
        wait_n(30);
        chk("warn at power on", 32'(warn), 32'h0);
        fwd_lim <= 1'h1;
        xfer(1'h1, OTSW_ADDR_WARN_EN, 32'h0);
        rev_lim <= 1'h0;
        wait_n(6);
        chk("warn disabled", 32'(warn), 32'h0);
        rev_lim <= 1'h1;
        reset <= 1'h1;
        wait_n(2);
        chk("reset outputs", {28'h0, brake, warn, act}, 32'h0);
        reset <= 1'h0;
        rd_chk("maxtrq rereset", OTSW_ADDR_MAX_TRQ, 32'h12C);
        close_out();
    end
endmodule
